// >>> hw/tap_pkg.sv
/*
  Constants for the boundary-scan test access port: controller states,
  instruction codes, register lengths and reset values.
  Assumes a single system clock that oversamples the test clock.
*/
// Notes on behaviour
// - Sixteen-state controller, instruction register and three selectable data registers.
// - Bypass register is one stage between test data in and out.
// - Boundary register of 256 cells chains all pins into one shift path.
// - 32-bit identification register shifts out serially when selected.
// - Test logic is separate; function untouched unless a test instruction owns pins.
// - Pins are captured while running and shifted out without disturbing them.
// - Under the high-impedance instruction all pin output drivers are turned off.
// - Under the extest instruction output pins hold boundary register values.
package tap_pkg;
  localparam int unsigned IR_LEN    = 4;
  localparam int unsigned BSR_LEN   = 256;
  localparam int unsigned ID_LEN    = 32;
  localparam int unsigned PIN_COUNT = 128;

  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAP_DR     = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPD_DR     = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAP_IR     = 4'ha,
    ST_SHIFT_IR   = 4'hb,
    ST_EXIT1_IR   = 4'hc,
    ST_PAUSE_IR   = 4'hd,
    ST_EXIT2_IR   = 4'he,
    ST_UPD_IR     = 4'hf
  } tap_state_type;

  localparam logic [IR_LEN-1:0] INS_EXTEST  = 4'h0;
  localparam logic [IR_LEN-1:0] INS_IDCODE  = 4'h1;
  localparam logic [IR_LEN-1:0] INS_SAMPLE  = 4'h2;
  localparam logic [IR_LEN-1:0] INS_HIGHZ   = 4'h9;
  localparam logic [IR_LEN-1:0] INS_CLAMP   = 4'hc;
  localparam logic [IR_LEN-1:0] INS_BYPASS  = 4'hf;
  localparam logic [IR_LEN-1:0] IR_CAPTURE  = 4'h1;
  // Identification value is arbitrary; bit 0 must stay one.
  localparam logic [ID_LEN-1:0] ID_DEFAULT  = 32'h0a5c_3001;
endpackage : tap_pkg

// >>> hw/tap_fsm.sv
/*
  Sixteen-state test controller, advanced once per test clock rising edge.
  Assumes adv_i is a single-cycle pulse and tms_i is already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_fsm (
  input  wire logic              clk_sys_i, // System clock.
  input  wire logic              resetn_i,  // Synchronous reset, active low.
  input  wire logic              trstn_i,   // Test reset, synchronised.
  input  wire logic              adv_i,     // Test clock rising edge seen.
  input  wire logic              tms_i,     // Mode select, synchronised.
  output var tap_pkg::tap_state_type state_o // Current controller state.
);
  import tap_pkg::*;
  tap_state_type state_q, state_d;

  always_comb begin
    state_d = state_q;
    if (adv_i) begin
      case (state_q)
        ST_RESET:    state_d = tms_i ? ST_RESET    : ST_IDLE;
        ST_IDLE:     state_d = tms_i ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_DR:   state_d = tms_i ? ST_SEL_IR   : ST_CAP_DR;
        ST_CAP_DR:   state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: state_d = tms_i ? ST_UPD_DR   : ST_PAUSE_DR;
        ST_PAUSE_DR: state_d = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: state_d = tms_i ? ST_UPD_DR   : ST_SHIFT_DR;
        ST_UPD_DR:   state_d = tms_i ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_IR:   state_d = tms_i ? ST_RESET    : ST_CAP_IR;
        ST_CAP_IR:   state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: state_d = tms_i ? ST_UPD_IR   : ST_PAUSE_IR;
        ST_PAUSE_IR: state_d = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: state_d = tms_i ? ST_UPD_IR   : ST_SHIFT_IR;
        ST_UPD_IR:   state_d = tms_i ? ST_SEL_DR   : ST_IDLE;
        default:     state_d = ST_RESET;
      endcase
    end
    if (!trstn_i) begin
      state_d = ST_RESET;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o = state_q;
endmodule // tap_fsm
`default_nettype wire

// >>> hw/boundary_scan_tap.sv
/*
  Boundary-scan test access port: instruction register, bypass, boundary
  and identification registers, and the pin multiplexing they control.
  Assumes the test clock is far slower than clk_sys_i (at least four
  system cycles per test clock phase) and that pins are bidirectional.
*/
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap #(
  parameter int unsigned       PINS   = tap_pkg::PIN_COUNT, // Pin count.
  parameter logic [31:0]       ID_VAL = tap_pkg::ID_DEFAULT // Arbitrary.
) (
  input  wire logic            clk_sys_i,   // System clock, 100 MHz.
  input  wire logic            resetn_i,    // Synchronous reset, low.
  input  wire logic            tck_i,       // Test clock pin.
  input  wire logic            tms_i,       // Test mode select pin.
  input  wire logic            tdi_i,       // Test data in pin.
  input  wire logic            trstn_i,     // Test reset pin, low.
  output logic                 tdo_o,       // Test data out.
  output logic                 tdo_oe_o,    // Test data out enable.
  input  wire logic [PINS-1:0] core_out_i,  // Functional output values.
  input  wire logic [PINS-1:0] core_oe_i,   // Functional output enables.
  output logic      [PINS-1:0] core_in_o,   // Pin levels to the core.
  input  wire logic [PINS-1:0] pad_in_i,    // Pad input levels.
  output logic      [PINS-1:0] pad_out_o,   // Pad output values.
  output logic      [PINS-1:0] pad_oe_o,    // Pad output enables.
  output var tap_pkg::tap_state_type state_o // Controller state.
);
  import tap_pkg::*;

  // Cells: [PINS-1:0] pin data, [2*PINS-1:PINS] pin enables.
  // Twice PINS must equal CELLS; with a smaller pin count the two halves
  // no longer fill the register and the upper cells are left unused.
  localparam int unsigned CELLS = BSR_LEN;

  logic [2:0] tck_s_q, tck_s_d;
  logic [1:0] tms_s_q, tms_s_d;
  logic [1:0] tdi_s_q, tdi_s_d;
  logic [1:0] trst_s_q, trst_s_d;
  logic       rise, fall;
  tap_state_type st;

  logic [IR_LEN-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic              byp_q, byp_d;
  logic [CELLS-1:0]  bsr_sh_q, bsr_sh_d, bsr_up_q, bsr_up_d;
  logic [ID_LEN-1:0] id_sh_q, id_sh_d;
  logic              tdo_q, tdo_d, tdoe_q, tdoe_d;
  logic [PINS-1:0]   pad_out_q, pad_out_d, pad_oe_q, pad_oe_d;
  logic [PINS-1:0]   core_in_q, core_in_d;
  logic [PINS-1:0]   pin_in_s1_q, pin_in_s2_q;

  // Pin levels are asynchronous and pass two stages before any use.
  // The test clock has a third stage so that its edge is found from two
  // settled copies, which keeps it in step with the mode and data copies.
  assign tck_s_d  = {tck_s_q[1:0], tck_i};
  assign tms_s_d  = {tms_s_q[0], tms_i};
  assign tdi_s_d  = {tdi_s_q[0], tdi_i};
  assign trst_s_d = {trst_s_q[0], trstn_i};
  // Edges are found from the second and third stages only.
  assign rise = tck_s_q[1] & ~tck_s_q[2];
  assign fall = ~tck_s_q[1] & tck_s_q[2];

  tap_fsm u_fsm (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .trstn_i   (trst_s_q[1]),
    .adv_i     (rise),
    .tms_i     (tms_s_q[1]),
    .state_o   (st)
  );

  // Instructions that take the pins away from the core.
  function automatic logic is_ext(input logic [IR_LEN-1:0] ins);
    return (ins == INS_EXTEST) || (ins == INS_CLAMP) || (ins == INS_HIGHZ);
  endfunction

  // Instructions that capture into and shift the boundary register.
  function automatic logic uses_bsr(input logic [IR_LEN-1:0] ins);
    return (ins == INS_EXTEST) || (ins == INS_SAMPLE);
  endfunction

  // Test registers other than the instruction, which the reset state reloads,
  // move only on a detected rising test clock, so a stopped test clock
  // freezes them. A phase shorter than one system cycle can be missed
  // altogether, which limits the test clock rate.
  always_comb begin
    ir_sh_d  = ir_sh_q;
    ir_d     = ir_q;
    byp_d    = byp_q;
    bsr_sh_d = bsr_sh_q;
    bsr_up_d = bsr_up_q;
    id_sh_d  = id_sh_q;
    if (rise) begin
      case (st)
        ST_CAP_IR:   ir_sh_d = IR_CAPTURE;
        ST_SHIFT_IR: ir_sh_d = {tdi_s_q[1], ir_sh_q[IR_LEN-1:1]};
        ST_CAP_DR: begin
          byp_d   = 1'b0;
          id_sh_d = ID_VAL;
          if (uses_bsr(ir_q)) begin
            // Capture only reads pins; pads keep their own drive.
            bsr_sh_d[PINS-1:0]      = pin_in_s2_q;
            bsr_sh_d[2*PINS-1:PINS] = pad_oe_q;
          end
        end
        ST_SHIFT_DR: begin
          case (ir_q)
            INS_IDCODE: id_sh_d = {tdi_s_q[1], id_sh_q[ID_LEN-1:1]};
            INS_EXTEST, INS_SAMPLE:
              bsr_sh_d = {tdi_s_q[1], bsr_sh_q[CELLS-1:1]};
            default: byp_d = tdi_s_q[1];
          endcase
        end
        ST_UPD_DR: begin
          if (uses_bsr(ir_q)) begin
            bsr_up_d = bsr_sh_q;
          end
        end
        ST_UPD_IR: ir_d = ir_sh_q;
        default: ;
      endcase
    end
    // The reset state falls back to the identification instruction, so a
    // tester that has just reset the port always reads the ID first.
    if (st == ST_RESET) begin
      ir_d = INS_IDCODE;
    end
  end

  // Data out moves on the falling edge, which gives the tester a whole low
  // phase of settling before the rising edge at which it samples.
  always_comb begin
    tdo_d  = tdo_q;
    tdoe_d = tdoe_q;
    if (fall) begin
      tdoe_d = (st == ST_SHIFT_DR) || (st == ST_SHIFT_IR);
      if (st == ST_SHIFT_IR) begin
        tdo_d = ir_sh_q[0];
      end else begin
        case (ir_q)
          INS_IDCODE:             tdo_d = id_sh_q[0];
          INS_EXTEST, INS_SAMPLE: tdo_d = bsr_sh_q[0];
          default:                tdo_d = byp_q;
        endcase
      end
    end
  end

  // Functional path stays live unless an external instruction is loaded.
  // High impedance is tested first because it must never drive any pin.
  // The core input path keeps a fixed three-cycle latency in every mode.
  always_comb begin
    pad_out_d = core_out_i;
    pad_oe_d  = core_oe_i;
    core_in_d = pin_in_s2_q;
    if (ir_q == INS_HIGHZ) begin
      pad_oe_d = '0;
    end else if (is_ext(ir_q)) begin
      pad_out_d = bsr_up_q[PINS-1:0];
      pad_oe_d  = bsr_up_q[2*PINS-1:PINS];
    end
  end

  // Mode select and data synchronisers reset high, the idle level of a
  // released test bus, so no false step is seen after reset.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tck_s_q     <= '0;
      tms_s_q     <= 2'h3;
      tdi_s_q     <= 2'h3;
      trst_s_q    <= '0;
      ir_sh_q     <= '0;
      ir_q        <= INS_IDCODE;
      byp_q       <= 1'b0;
      bsr_sh_q    <= '0;
      bsr_up_q    <= '0;
      id_sh_q     <= '0;
      tdo_q       <= 1'b0;
      tdoe_q      <= 1'b0;
      pad_out_q   <= '0;
      pad_oe_q    <= '0;
      core_in_q   <= '0;
      pin_in_s1_q <= '0;
      pin_in_s2_q <= '0;
    end else begin
      tck_s_q     <= tck_s_d;
      tms_s_q     <= tms_s_d;
      tdi_s_q     <= tdi_s_d;
      trst_s_q    <= trst_s_d;
      ir_sh_q     <= ir_sh_d;
      ir_q        <= ir_d;
      byp_q       <= byp_d;
      bsr_sh_q    <= bsr_sh_d;
      bsr_up_q    <= bsr_up_d;
      id_sh_q     <= id_sh_d;
      tdo_q       <= tdo_d;
      tdoe_q      <= tdoe_d;
      pad_out_q   <= pad_out_d;
      pad_oe_q    <= pad_oe_d;
      core_in_q   <= core_in_d;
      pin_in_s1_q <= pad_in_i;
      pin_in_s2_q <= pin_in_s1_q;
    end
  end

  assign tdo_o     = tdo_q;
  assign tdo_oe_o  = tdoe_q;
  assign pad_out_o = pad_out_q;
  assign pad_oe_o  = pad_oe_q;
  assign core_in_o = core_in_q;
  assign state_o   = st;
endmodule // boundary_scan_tap
`default_nettype wire

// >>> sim/boundary_scan_tap_assertions.sv
/*
  Checker for the test port, bound to its top module.
  Assumes the test clock phases last far longer than four system cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_assertions
  import tap_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
) (
  input wire logic            clk_sys_i,  // System clock.
  input wire logic            resetn_i,   // Reset, active low.
  input wire logic            tck_i,      // Test clock pin.
  input wire logic            trstn_i,    // Test reset pin.
  input wire logic            tdo_o,      // Test data out.
  input wire logic            tdo_oe_o,   // Test data out enable.
  input wire logic [PINS-1:0] core_out_i, // Functional values.
  input wire logic [PINS-1:0] core_oe_i,  // Functional enables.
  input wire logic [PINS-1:0] core_in_o,  // Pin levels to core.
  input wire logic [PINS-1:0] pad_in_i,   // Pad levels.
  input wire logic [PINS-1:0] pad_out_o,  // Pad drive.
  input wire logic [PINS-1:0] pad_oe_o,   // Pad enables.
  input wire tap_state_type   state_o     // Controller state.
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_tdo_on_fall: assert property (
    $changed(tdo_o) |-> !tck_i) else $error("tdo moved while tck high");
  a_step_on_rise: assert property (
    $changed(state_o) && trstn_i && $past(trstn_i, 4) |-> tck_i)
    else $error("state moved while tck low");
  a_shift_dr_exit: assert property (
    $past(state_o) == ST_SHIFT_DR
    && !(state_o inside {ST_SHIFT_DR, ST_RESET}) |-> state_o == ST_EXIT1_DR)
    else $error("bad step out of shift-dr");
  a_idle_next: assert property (
    $past(state_o) == ST_IDLE
    && !(state_o inside {ST_IDLE, ST_RESET}) |-> state_o == ST_SEL_DR)
    else $error("bad step out of idle");
  a_trst_forces: assert property (
    $fell(trstn_i) |-> ##[1:4] state_o == ST_RESET)
    else $error("test reset not obeyed");
  a_oe_in_shift: assert property (
    $rose(tdo_oe_o) |-> state_o inside {ST_SHIFT_DR, ST_SHIFT_IR})
    else $error("tdo enabled outside shift");
  a_func_in_reset: assert property (
    state_o == ST_RESET && $past(state_o, 2) == ST_RESET
    |=> pad_out_o == $past(core_out_i) && pad_oe_o == $past(core_oe_i))
    else $error("pins not functional in reset");
  a_core_in_sync: assert property (
    $past(resetn_i, 4) |-> core_in_o == $past(pad_in_i, 3))
    else $error("core input path disturbed");
endmodule // boundary_scan_tap_assertions
`default_nettype wire

// >>> sim/tap_master.sv
/*
  Board tester model that drives the test port pins.
  Assumes clk_i is the bench clock; the test clock is 160 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_master (
  input  wire logic clk_i,   // Bench clock.
  input  wire logic tdo_i,   // Test data out.
  output logic      tck_o,   // Test clock, low between frames.
  output logic      tms_o,   // Mode select.
  output logic      tdi_o,   // Test data in.
  output logic      trstn_o  // Test reset, active low.
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trstn_o = 1'b1;
  end
  task automatic half();
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  // Inputs settle a full phase ahead of the rising edge that samples them.
  task automatic step(input logic m, input logic dv, output logic q);
    tms_o = m;
    tdi_o = dv;
    half();
    q = tdo_i;
    tck_o = 1'b1;
    half();
    tck_o = 1'b0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [255:0] din,
                      output logic [255:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(logic'(i == n - 1), din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  task automatic reset_port();
    logic q;
    trstn_o = 1'b0;
    half();
    trstn_o = 1'b1;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // tap_master
`default_nettype wire

// >>> sim/boundary_scan_tap_tb_top.sv
/*
  Bench top for the test port: tester model, checker bind and scenarios.
  Assumes the tester model owns every test pin.
*/
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_tb_top;
  import tap_pkg::*;
  localparam logic [127:0] D = {4{32'hc3a5_0f96}};
  localparam logic [127:0] E = {4{32'h00ff_f00f}};
  logic                   clk_sys_i;
  logic                   resetn_i;
  logic                   tck, tms, tdi, trstn, tdo, tdo_oe;
  logic [PIN_COUNT-1:0]   core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [255:0]           d;
  tap_state_type          state;
  int                     failures = 0;
  int                     checked = 0;
  boundary_scan_tap DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trstn_i(trstn), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .core_out_i(core_out), .core_oe_i(core_oe),
    .core_in_o(core_in), .pad_in_i(pad_in), .pad_out_o(pad_out),
    .pad_oe_o(pad_oe), .state_o(state));
  tap_master m (.clk_i(clk_sys_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .trstn_o(trstn));
  task automatic chk(input string nm, input logic [255:0] exp, got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic load_ir(input logic [3:0] code);
    m.scan(1'b1, 4, 256'(code), d);
    chk("ir capture", 256'(IR_CAPTURE), 256'(d[3:0]));
    chk("ir state", 256'(ST_IDLE), 256'(state));
    chk("oe idle", 256'h0, 256'(tdo_oe));
  endtask
  task automatic t_idcode();
    m.reset_port();
    chk("reset state", 256'(ST_IDLE), 256'(state));
    m.scan(1'b0, 32, '0, d);
    chk("idcode", 256'(ID_DEFAULT), 256'(d[31:0]));
  endtask
  // Bypass captures zero, then echoes tdi one stage late.
  task automatic t_bypass();
    load_ir(INS_BYPASS);
    m.scan(1'b0, 8, 256'h5b, d);
    chk("bypass", 256'hb6, 256'(d[7:0]));
  endtask
  task automatic t_pins();
    load_ir(INS_SAMPLE);
    m.scan(1'b0, 256, {E, D}, d);
    chk("sample", 256'(pad_in), 256'(d[127:0]));
    chk("func", 256'(core_out), 256'(pad_out));
    chk("core in", 256'(pad_in), 256'(core_in));
    load_ir(INS_EXTEST);
    chk("extest", {E, D}, {pad_oe, pad_out});
    load_ir(INS_CLAMP);
    chk("clamp", {E, D}, {pad_oe, pad_out});
    load_ir(INS_HIGHZ);
    chk("highz", 256'h0, 256'(pad_oe));
    m.reset_port();
    chk("released", {core_oe, core_out}, {pad_oe, pad_out});
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    resetn_i = 1'b0;
    core_out = {4{32'h1234_abcd}};
    core_oe = {4{32'hffff_0000}};
    pad_in = {4{32'h9e37_79b9}};
    repeat (3) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    t_idcode();
    t_bypass();
    t_pins();
    final_report();
  end
  initial begin
    #900000;
    failures++;
    final_report();
  end
endmodule // boundary_scan_tap_tb_top
bind boundary_scan_tap boundary_scan_tap_assertions #(.PINS(PINS)) chk_i (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .tck_i(tck_i),
  .trstn_i(trstn_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .core_out_i(core_out_i), .core_oe_i(core_oe_i), .core_in_o(core_in_o),
  .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
  .state_o(state_o));
`default_nettype wire
